// File: hw/sad_map.svh
`ifndef SAD_MAP_SVH
`define SAD_MAP_SVH
`define SAD_CODE_LO       32'h0000_0000
`define SAD_CODE_HI       32'h1fff_ffff
`define SAD_DATA_LO       32'h2000_0000
`define SAD_DATA_HI       32'h3fff_ffff
`define SAD_PERI_LO       32'h4000_0000
`define SAD_PERI_HI       32'h5fff_ffff
`define SAD_XRAM_LO       32'h6000_0000
`define SAD_XRAM_HI       32'h9fff_ffff
`define SAD_XDEV_LO       32'ha000_0000
`define SAD_XDEV_HI       32'hdfff_ffff
`define SAD_PPB_LO        32'he000_0000
`define SAD_PPB_HI        32'he00f_ffff
`define SAD_SYS_LO        32'he010_a000
`define SAD_SYS_HI        32'hffff_ffff
`define SAD_ROM_LO        32'h0000_0000
`define SAD_ROM_HI        32'h0000_ffff
`define SAD_SRAM_LO       32'h0800_0000
`define SAD_SRAM_HI       32'h0801_ffff
`define SAD_FLASH_LO      32'h1000_0000
`define SAD_FLASH_HI      32'h1003_ffff
`define SAD_SUPV_FLASH_LO 32'h1600_0000
`define SAD_SUPV_FLASH_HI 32'h1600_7fff
`define SAD_RESET_TGT     4'h0
`endif

// File: hw/sad_pkg.sv
package sad_pkg;
    // target codes; none means the access is answered with a bus error
    typedef enum logic [3:0] {
        SAD_TGT_NONE       = 4'h0,
        SAD_TGT_ROM        = 4'h1,
        SAD_TGT_SRAM       = 4'h2,
        SAD_TGT_FLASH      = 4'h3,
        SAD_TGT_SUPV_FLASH = 4'h4,
        SAD_TGT_PERI       = 4'h5,
        SAD_TGT_SERIAL_MEM = 4'h6,
        SAD_TGT_PPB        = 4'h7,
        SAD_TGT_SYS        = 4'h8
    } sad_tgt_e;

    typedef struct packed {
        logic        valid;
        logic        fetch;
        logic        write;
        logic [31:0] addr;
    } sad_req_s;

    typedef struct packed {
        logic        valid;
        sad_tgt_e    tgt;
        logic        err;
        logic        write;
        logic [31:0] addr;
    } sad_sel_s;
endpackage : sad_pkg

// File: hw/sad_decode.sv
`timescale 1ns/1ns
`include "sad_map.svh"
// one registered decode lane; both cores use identical copies
module sad_decode (
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire sad_pkg::sad_req_s req_i,
    output sad_pkg::sad_sel_s      sel_o
);
    import sad_pkg::*;

    typedef struct packed {
        sad_sel_s sel;
    } sad_dec_state_s;

    sad_dec_state_s state_q;
    sad_dec_state_s state_d;

    function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo,
                                    input logic [31:0] hi);
        in_rng = (a >= lo) && (a <= hi);
    endfunction : in_rng

    // full 32-bit compare, one answer per request, no wait state
    always_comb begin
        sad_tgt_e tgt;
        logic     fetch_ok;
        tgt      = SAD_TGT_NONE;
        fetch_ok = 1'b0;
        if (in_rng(req_i.addr, `SAD_CODE_LO, `SAD_CODE_HI)) begin
            fetch_ok = 1'b1;
            if (in_rng(req_i.addr, `SAD_ROM_LO, `SAD_ROM_HI)) begin
                tgt = SAD_TGT_ROM;
            end else if (in_rng(req_i.addr, `SAD_SRAM_LO, `SAD_SRAM_HI)) begin
                tgt = SAD_TGT_SRAM;
            end else if (in_rng(req_i.addr, `SAD_FLASH_LO, `SAD_FLASH_HI)) begin
                tgt = SAD_TGT_FLASH;
            end else if (in_rng(req_i.addr, `SAD_SUPV_FLASH_LO, `SAD_SUPV_FLASH_HI)) begin
                tgt = SAD_TGT_SUPV_FLASH;
            end
        end else if (in_rng(req_i.addr, `SAD_DATA_LO, `SAD_DATA_HI)) begin
            tgt = SAD_TGT_NONE;
        end else if (in_rng(req_i.addr, `SAD_PERI_LO, `SAD_PERI_HI)) begin
            tgt = SAD_TGT_PERI; // plain window, no bit-band remap
        end else if (in_rng(req_i.addr, `SAD_XRAM_LO, `SAD_XRAM_HI)) begin
            tgt      = SAD_TGT_SERIAL_MEM;
            fetch_ok = 1'b1;
        end else if (in_rng(req_i.addr, `SAD_XDEV_LO, `SAD_XDEV_HI)) begin
            tgt = SAD_TGT_NONE;
        end else if (in_rng(req_i.addr, `SAD_PPB_LO, `SAD_PPB_HI)) begin
            tgt = SAD_TGT_PPB;
        end else if (in_rng(req_i.addr, `SAD_SYS_LO, `SAD_SYS_HI)) begin
            tgt = SAD_TGT_SYS;
        end
        // a refused fetch must never reach a target
        if (req_i.fetch && !fetch_ok) begin
            tgt = SAD_TGT_NONE;
        end
        state_d.sel.valid = req_i.valid;
        state_d.sel.tgt   = req_i.valid ? tgt : sad_tgt_e'(`SAD_RESET_TGT);
        state_d.sel.err   = req_i.valid && (tgt == SAD_TGT_NONE);
        state_d.sel.write = req_i.write;
        state_d.sel.addr  = req_i.addr;
    end

    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign sel_o = state_q.sel;

    // peripheral fetch is refused next cycle
    peri_fetch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_i.valid && req_i.fetch && req_i.addr[31:29] == 3'h2 |=> sel_o.err)
        else $error("fetch from peripheral region not refused");
endmodule : sad_decode

// File: hw/sad_top.sv
`timescale 1ns/1ns
`include "sad_map.svh"
// two identical decode lanes, one per core; a single map serves both
module sad_top (
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire sad_pkg::sad_req_s primary_core_req_i,
    input  wire sad_pkg::sad_req_s secondary_core_req_i,
    output sad_pkg::sad_sel_s      primary_core_sel_o,
    output sad_pkg::sad_sel_s      secondary_core_sel_o
);
    import sad_pkg::*;

    // same module for both keeps the maps identical by construction
    sad_decode u_primary (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .req_i     (primary_core_req_i),
        .sel_o     (primary_core_sel_o)
    );

    sad_decode u_secondary (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .req_i     (secondary_core_req_i),
        .sel_o     (secondary_core_sel_o)
    );

    // sequence: a valid request answered next cycle
    sequence req_taken_s;
        primary_core_req_i.valid;
    endsequence

    rom_select_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:16] == 16'h0000)
        |=> primary_core_sel_o.tgt == SAD_TGT_ROM && !primary_core_sel_o.err)
        else $error("rom address not routed to rom");
    sram_select_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:17] == 15'h0400)
        |=> primary_core_sel_o.tgt == SAD_TGT_SRAM)
        else $error("sram address misrouted");
    flash_select_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:18] == 14'h0400)
        |=> primary_core_sel_o.tgt == SAD_TGT_FLASH)
        else $error("flash address misrouted");
    supv_flash_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:15] == 17'h02c00)
        |=> primary_core_sel_o.tgt == SAD_TGT_SUPV_FLASH)
        else $error("supervisory flash address misrouted");
    data_empty_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:29] == 3'h1)
        |=> primary_core_sel_o.err)
        else $error("data region did not error");
    xdev_unused_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:29] == 3'h5
            || primary_core_req_i.addr[31:29] == 3'h6)
        |=> primary_core_sel_o.err)
        else $error("external device region did not error");
    serial_exec_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:29] == 3'h3
            || primary_core_req_i.addr[31:29] == 3'h4)
        |=> primary_core_sel_o.tgt == SAD_TGT_SERIAL_MEM && !primary_core_sel_o.err)
        else $error("serial memory fetch or access refused");
    ppb_select_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:20] == 12'he00)
            ##0 !primary_core_req_i.fetch
        |=> primary_core_sel_o.tgt == SAD_TGT_PPB)
        else $error("private bus address misrouted");
    no_stall_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        secondary_core_req_i.valid |=> secondary_core_sel_o.valid
            && (secondary_core_sel_o.err == (secondary_core_sel_o.tgt == SAD_TGT_NONE)))
        else $error("secondary request not answered in one cycle");
    same_map_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        primary_core_req_i == secondary_core_req_i && primary_core_req_i.valid
        |=> primary_core_sel_o == secondary_core_sel_o)
        else $error("cores see different maps");

    // primary lane: peripheral and system windows take data but never a fetch
    pri_peri_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:29] == 3'h2)
            ##0 !primary_core_req_i.fetch
        |=> primary_core_sel_o.tgt == SAD_TGT_PERI && !primary_core_sel_o.err)
        else $error("peripheral access misrouted");
    pri_sys_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:28] == 4'hf)
            ##0 !primary_core_req_i.fetch
        |=> primary_core_sel_o.tgt == SAD_TGT_SYS && !primary_core_sel_o.err)
        else $error("system register access misrouted");
    vector_base_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr == 32'h0000_0000)
        |=> primary_core_sel_o.tgt == SAD_TGT_ROM && !primary_core_sel_o.err)
        else $error("vector at zero not served");
    ppb_fetch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:20] == 12'he00)
            ##0 primary_core_req_i.fetch
        |=> primary_core_sel_o.err && primary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("fetch from private bus not refused");
    sys_fetch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:28] == 4'hf)
            ##0 primary_core_req_i.fetch
        |=> primary_core_sel_o.err && primary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("fetch from system registers not refused");
    code_fetch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:18] == 14'h0400)
            ##0 primary_core_req_i.fetch
        |=> primary_core_sel_o.tgt == SAD_TGT_FLASH && !primary_core_sel_o.err)
        else $error("fetch from flash refused");

    // a hole inside or between decoded regions answers on the next cycle with an error, never a stall
    code_gap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:16] == 16'h0001)
        |=> primary_core_sel_o.err && primary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("gap after rom did not error");
    sys_gap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s ##0 (primary_core_req_i.addr[31:16] == 16'he010
            && primary_core_req_i.addr[15:12] < 4'ha)
        |=> primary_core_sel_o.err && primary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("gap below system registers did not error");

    // an idle cycle leaves the lane quiet; a taken one is answered and echoed
    pri_idle_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !primary_core_req_i.valid |=> !primary_core_sel_o.valid
            && primary_core_sel_o.tgt == SAD_TGT_NONE && !primary_core_sel_o.err)
        else $error("idle primary cycle not quiet");
    pri_no_stall_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        primary_core_req_i.valid |=> primary_core_sel_o.valid
            && (primary_core_sel_o.err == (primary_core_sel_o.tgt == SAD_TGT_NONE)))
        else $error("primary request not answered in one cycle");
    pri_echo_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        req_taken_s
        |=> primary_core_sel_o.addr == $past(primary_core_req_i.addr)
            && primary_core_sel_o.write == $past(primary_core_req_i.write))
        else $error("primary address not passed on whole");

    // secondary lane: the same checks again, so neither core can drift from the map
    sequence sec_taken_s;
        secondary_core_req_i.valid;
    endsequence

    sec_rom_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:16] == 16'h0000)
        |=> secondary_core_sel_o.tgt == SAD_TGT_ROM && !secondary_core_sel_o.err)
        else $error("secondary rom address misrouted");
    sec_sram_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:17] == 15'h0400)
        |=> secondary_core_sel_o.tgt == SAD_TGT_SRAM && !secondary_core_sel_o.err)
        else $error("secondary sram address misrouted");
    sec_flash_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:18] == 14'h0400)
        |=> secondary_core_sel_o.tgt == SAD_TGT_FLASH && !secondary_core_sel_o.err)
        else $error("secondary flash address misrouted");
    sec_supv_flash_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:15] == 17'h02c00)
        |=> secondary_core_sel_o.tgt == SAD_TGT_SUPV_FLASH && !secondary_core_sel_o.err)
        else $error("secondary supervisory flash address misrouted");
    sec_data_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:29] == 3'h1)
        |=> secondary_core_sel_o.err && secondary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("secondary data region did not error");
    sec_xdev_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:29] == 3'h5
            || secondary_core_req_i.addr[31:29] == 3'h6)
        |=> secondary_core_sel_o.err && secondary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("secondary external device region did not error");
    sec_serial_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:29] == 3'h3
            || secondary_core_req_i.addr[31:29] == 3'h4)
        |=> secondary_core_sel_o.tgt == SAD_TGT_SERIAL_MEM && !secondary_core_sel_o.err)
        else $error("secondary serial memory access refused");
    sec_ppb_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:20] == 12'he00)
            ##0 !secondary_core_req_i.fetch
        |=> secondary_core_sel_o.tgt == SAD_TGT_PPB && !secondary_core_sel_o.err)
        else $error("secondary private bus address misrouted");
    sec_peri_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:29] == 3'h2)
            ##0 !secondary_core_req_i.fetch
        |=> secondary_core_sel_o.tgt == SAD_TGT_PERI && !secondary_core_sel_o.err)
        else $error("secondary peripheral access misrouted");
    sec_sys_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:28] == 4'hf)
            ##0 !secondary_core_req_i.fetch
        |=> secondary_core_sel_o.tgt == SAD_TGT_SYS && !secondary_core_sel_o.err)
        else $error("secondary system register access misrouted");
    sec_vector_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr == 32'h0000_0000)
        |=> secondary_core_sel_o.tgt == SAD_TGT_ROM && !secondary_core_sel_o.err)
        else $error("secondary vector at zero not served");
    sec_ppb_fetch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:20] == 12'he00)
            ##0 secondary_core_req_i.fetch
        |=> secondary_core_sel_o.err && secondary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("secondary fetch from private bus not refused");
    sec_sys_fetch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:28] == 4'hf)
            ##0 secondary_core_req_i.fetch
        |=> secondary_core_sel_o.err && secondary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("secondary fetch from system registers not refused");
    sec_code_fetch_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:18] == 14'h0400)
            ##0 secondary_core_req_i.fetch
        |=> secondary_core_sel_o.tgt == SAD_TGT_FLASH && !secondary_core_sel_o.err)
        else $error("secondary fetch from flash refused");
    sec_code_gap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:16] == 16'h0001)
        |=> secondary_core_sel_o.err && secondary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("secondary gap after rom did not error");
    sec_sys_gap_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s ##0 (secondary_core_req_i.addr[31:16] == 16'he010
            && secondary_core_req_i.addr[15:12] < 4'ha)
        |=> secondary_core_sel_o.err && secondary_core_sel_o.tgt == SAD_TGT_NONE)
        else $error("secondary gap below system registers did not error");
    sec_idle_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !secondary_core_req_i.valid |=> !secondary_core_sel_o.valid
            && secondary_core_sel_o.tgt == SAD_TGT_NONE && !secondary_core_sel_o.err)
        else $error("idle secondary cycle not quiet");
    sec_echo_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
        sec_taken_s
        |=> secondary_core_sel_o.addr == $past(secondary_core_req_i.addr)
            && secondary_core_sel_o.write == $past(secondary_core_req_i.write))
        else $error("secondary address not passed on whole");
endmodule : sad_top

// File: test/sad_core_model.sv
`timescale 1ns/1ns
// behavioural bus master: one request per cycle, launched just after the edge
module sad_core_model (
    input  wire logic              sys_clk_i,
    input  wire sad_pkg::sad_req_s next_i,
    output sad_pkg::sad_req_s      req_o
);
    import sad_pkg::*;
    // no ready exists, so a request is simply replaced each cycle
    always @(posedge sys_clk_i) req_o <= #1 next_i;
endmodule : sad_core_model

// File: test/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import sad_pkg::*;
    logic        sys_clk_i;
    logic        reset_i;
    logic        chk;
    logic [31:0] r;
    logic [31:0] corner [24];
    sad_req_s    nxt_p, nxt_s, req_p, req_s;
    sad_sel_s    sel_p, sel_s, exp_p, exp_s;
    int          fails, n_compared, cyc, seed, i;
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end
    sad_core_model core_p (.sys_clk_i(sys_clk_i), .next_i(nxt_p), .req_o(req_p));
    sad_core_model core_s (.sys_clk_i(sys_clk_i), .next_i(nxt_s), .req_o(req_s));
    sad_top dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .primary_core_req_i(req_p),
        .secondary_core_req_i(req_s), .primary_core_sel_o(sel_p),
        .secondary_core_sel_o(sel_s));
    function automatic bit inr(logic [31:0] a, logic [31:0] lo, logic [31:0] hi);
        return a >= lo && a <= hi;
    endfunction : inr
    // target from the map; anything unlisted is a gap
    function automatic sad_tgt_e tgt_of(logic [31:0] a);
        if (a <= 32'h0000_ffff) return SAD_TGT_ROM;
        if (inr(a, 32'h0800_0000, 32'h0801_ffff)) return SAD_TGT_SRAM;
        if (inr(a, 32'h1000_0000, 32'h1003_ffff)) return SAD_TGT_FLASH;
        if (inr(a, 32'h1600_0000, 32'h1600_7fff)) return SAD_TGT_SUPV_FLASH;
        if (inr(a, 32'h4000_0000, 32'h5fff_ffff)) return SAD_TGT_PERI;
        if (inr(a, 32'h6000_0000, 32'h9fff_ffff)) return SAD_TGT_SERIAL_MEM;
        if (inr(a, 32'he000_0000, 32'he00f_ffff)) return SAD_TGT_PPB;
        if (a >= 32'he010_a000) return SAD_TGT_SYS;
        return SAD_TGT_NONE;
    endfunction : tgt_of
    function automatic sad_sel_s expect_of(sad_req_s q);
        sad_sel_s e;
        e = '0;
        if (q.valid) begin
            e = sad_sel_s'({1'b1, tgt_of(q.addr), 1'b0, q.write, q.addr});
            // fetch is only legal in the code and external ram regions
            if (q.fetch && !(q.addr <= 32'h1fff_ffff || inr(q.addr, 32'h6000_0000,
                32'h9fff_ffff))) e.tgt = SAD_TGT_NONE;
            e.err = (e.tgt == SAD_TGT_NONE);
        end
        return e;
    endfunction : expect_of
    task automatic check(input logic [38:0] seen, input logic [38:0] want);
        n_compared++;
        if (seen !== want) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, seen, want);
        end
    endtask : check
    task end_of_test;
        if (fails == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // expectation follows the request by exactly one edge, cleared by reset
    always @(posedge sys_clk_i) begin
        exp_p <= reset_i ? '0 : expect_of(req_p);
        exp_s <= reset_i ? '0 : expect_of(req_s);
        cyc++;
        if (cyc > 5000) begin
            fails++;
            end_of_test();
        end
    end
    // idle cycles only promise valid, target and error low
    always @(negedge sys_clk_i) if (chk) begin
        check(exp_p.valid ? sel_p : sel_p & 39'h7e_0000_0000, exp_p);
        check(exp_s.valid ? sel_s : sel_s & 39'h7e_0000_0000, exp_s);
    end
    initial begin
        seed = 32417;
        fails = 0;
        n_compared = 0;
        cyc = 0;
        chk = 1'b0;
        reset_i = 1'b1;
        nxt_p = '0;
        nxt_s = '0;
        corner = '{32'h0, 32'h0000_ffff, 32'h0001_0000, 32'h0800_0000, 32'h0801_ffff,
            32'h0802_0000, 32'h1000_0000, 32'h1003_ffff, 32'h1600_0000, 32'h1600_7fff,
            32'h1600_8000, 32'h2000_0000, 32'h3fff_ffff, 32'h4000_0000, 32'h5fff_ffff,
            32'h6000_0000, 32'h9fff_ffff, 32'ha000_0000, 32'hdfff_ffff, 32'he000_0000,
            32'he00f_ffff, 32'he010_9fff, 32'he010_a000, 32'hffff_ffff};
        repeat (8) @(posedge sys_clk_i);
        #1 reset_i = 1'b0;
        chk = 1'b1;
        // every boundary with each fetch and write mix, same address on both cores;
        // half the time both cores issue the very same request, so lanes match
        for (i = 0; i < 96; i++) begin
            @(posedge sys_clk_i);
            #1 nxt_p = '{1'b1, i[0], i[1], corner[(i / 4) % 24]};
            nxt_s = '{1'b1, i[0] ^ i[1], i[1], corner[(i / 4) % 24]};
        end
        // random traffic, half near the boundaries, with idle cycles mixed in
        for (i = 0; i < 2000; i++) begin
            @(posedge sys_clk_i);
            r = $random(seed);
            #1 nxt_p = '{r[0] | r[1], r[2], r[3], r[4] ? 32'($random(seed)) :
                corner[r[9:5] % 24] ^ {27'h0, r[14:10]}};
            r = $random(seed);
            nxt_s = '{r[0] | r[1], r[2], r[3], r[4] ? 32'($random(seed)) :
                corner[r[9:5] % 24] ^ {27'h0, r[14:10]}};
            if (i == 1000) reset_i = 1'b1;
            if (i == 1003) reset_i = 1'b0;
        end
        repeat (3) @(posedge sys_clk_i);
        end_of_test();
    end
endmodule : tb_top
